// ### common/wdbus_pkg.sv
// Package: register map, field positions and reset values of the two regs
package wdbus_pkg;
   localparam logic [6:0] ADDR_WDOG_CFG   = 7'h03;
   localparam logic [6:0] ADDR_BUS_MODE   = 7'h04;
   localparam logic [7:0] WDOG_CFG_RST    = 8'h14;
   localparam logic [7:0] BUS_MODE_RST    = 8'h20;
   localparam logic [2:0] WDOG_PERIOD_RST = 3'h4;
   localparam logic [4:0] BUS_FAILSAFE_LO = 5'h09;
   localparam int         FRAME_BITS      = 16;
   localparam int         WD_PARITY_BIT   = 7;
   localparam int         WD_STOP_DIS_BIT = 6;
   localparam int         WD_WINDOW_BIT   = 5;
   localparam int         WD_BUSWAKE_BIT  = 4;
   localparam int         WD_RSVD_BIT     = 3;
   localparam int         BM_FLASH_BIT    = 7;
   localparam int         BM_LSLOPE_BIT   = 6;
   localparam int         BM_TXDTO_BIT    = 5;
   localparam int         BM_SWK_BIT      = 2;
   localparam logic [1:0] MODE_OFF        = 2'h0;
   localparam logic [1:0] MODE_WAKE       = 2'h1;
   localparam logic [1:0] MODE_RXONLY     = 2'h2;
   localparam logic [1:0] MODE_NORMAL     = 2'h3;
   localparam logic [2:0] PERIOD_RSVD     = 3'h7;
   // Watchdog periods in ms, indexed by period code
   localparam int         PERIOD_MS [7]   = '{10, 20, 50, 100, 200, 500, 1000};
endpackage

// ### rtl/serial_frame_rx.sv
// Serial frame receiver: shifts a 16-bit write frame framed by chip select
`timescale 1ns/1ps
module serial_frame_rx
(
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic        chip_select_n_i,
   input  wire logic        sclk_i,
   input  wire logic        sdi_i,
   output logic             frame_done_o,
   output logic             frame_ok_o,
   output logic [15:0]      frame_o
);
   logic        sclk_q;
   logic        cs_q;
   logic [4:0]  count_q;

   // Edge history for the serial clock and chip select
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         sclk_q <= 1'b0;
         cs_q   <= 1'b1;
      end
      else
      begin
         sclk_q <= sclk_i;
         cs_q   <= chip_select_n_i;
      end
   end

   // MSB first on rising serial clock; count guards against short frames
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         frame_o <= 16'h0000;
         count_q <= 5'h00;
      end
      else if (chip_select_n_i)
         count_q <= 5'h00;
      else if (sclk_i && !sclk_q)
      begin
         frame_o <= {frame_o[14:0], sdi_i};
         if (count_q != 5'h1f)
            count_q <= count_q + 5'h01;
      end
   end

   // Frame ends on chip select rising; only exact-length frames are usable
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         frame_done_o <= 1'b0;
         frame_ok_o   <= 1'b0;
      end
      else
      begin
         frame_done_o <= chip_select_n_i && !cs_q;
         frame_ok_o   <= chip_select_n_i && !cs_q
                         && (count_q == 5'(wdbus_pkg::FRAME_BITS));
      end
   end
endmodule

// ### rtl/watchdog_and_bus_mode_regs.sv
// Watchdog configuration and bus transceiver mode registers with serial port
`timescale 1ns/1ps
module watchdog_and_bus_mode_regs
(
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic        soft_reset_i,
   input  wire logic        chip_select_n_i,
   input  wire logic        sclk_i,
   input  wire logic        sdi_i,
   input  wire logic        restart_entry_i,
   input  wire logic        failsafe_entry_i,
   input  wire logic        sleep_entry_i,
   input  wire logic        stop_entry_i,
   input  wire logic        in_stop_i,
   input  wire logic        can_bus_wake_i,
   input  wire logic        system_error_flag_i,
   output logic [7:0]       watchdog_config_o,
   output logic [7:0]       bus_transceiver_mode_o,
   output logic             wdog_stop_disable_lo_o,
   output logic             wdog_window_select_o,
   output logic [2:0]       wdog_period_sel_o,
   output logic             wdog_start_long_window_o,
   output logic             single_wire_slope_off_o,
   output logic             single_wire_low_slope_o,
   output logic             single_wire_txd_timeout_en_o,
   output logic [1:0]       single_wire_mode_o,
   output logic [1:0]       can_mode_o,
   output logic             selective_wake_o,
   output logic             access_fail_o
);
   logic        frame_done;
   logic        frame_ok;
   logic [15:0] frame;
   logic        wr_en;
   logic [6:0]  addr;
   logic [7:0]  wdata;
   logic        wr_wd;
   logic        wr_bus;
   logic [7:0]  wd_q;
   logic [7:0]  bus_q;
   logic [1:0]  can_lp;

   // Parity over a byte; even parity gives zero
   function automatic logic odd_parity(input logic [7:0] v);
      return ^v;
   endfunction

   // CAN low-power mode mapping for the two device-owned mode bits
   function automatic logic [1:0] can_low_power(input logic [1:0] m,
                                                input logic       sleep,
                                                input logic       system_error_flag);
      logic [1:0] r;
      r = m;
      if (sleep && !system_error_flag && m == wdbus_pkg::MODE_NORMAL)
         r = wdbus_pkg::MODE_WAKE;
      else if (sleep && m == wdbus_pkg::MODE_RXONLY)
         r = wdbus_pkg::MODE_WAKE;
      return r;
   endfunction

   serial_frame_rx u_rx
   (
      .clk_i           (clk_i),
      .srst_i          (srst_i),
      .chip_select_n_i (chip_select_n_i),
      .sclk_i          (sclk_i),
      .sdi_i           (sdi_i),
      .frame_done_o    (frame_done),
      .frame_ok_o      (frame_ok),
      .frame_o         (frame)
   );

   // Frame: bit 15 write flag, 14:8 address, 7:0 data
   assign wr_en  = frame_ok && frame[15];
   assign addr   = frame[14:8];
   assign wdata  = frame[7:0];
   assign wr_wd  = wr_en && addr == wdbus_pkg::ADDR_WDOG_CFG
                   && !odd_parity(wdata);
   assign wr_bus = wr_en && addr == wdbus_pkg::ADDR_BUS_MODE;
   assign can_lp = can_low_power(bus_q[1:0], sleep_entry_i,
                                 system_error_flag_i);

   // Watchdog config; restart outranks a host write in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (srst_i || soft_reset_i)
         wd_q <= wdbus_pkg::WDOG_CFG_RST;
      else if (restart_entry_i)
      begin
         wd_q[wdbus_pkg::WD_STOP_DIS_BIT] <= 1'b0;
         wd_q[wdbus_pkg::WD_RSVD_BIT]     <= 1'b0;
         wd_q[2:0] <= wdbus_pkg::WDOG_PERIOD_RST;
      end
      else if (wr_wd)
      begin
         wd_q <= wdata;
         wd_q[wdbus_pkg::WD_RSVD_BIT] <= 1'b0;
      end
   end

   // Bus mode; fail-safe first, then low-power entry, then host writes
   always_ff @(posedge clk_i)
   begin
      if (srst_i || soft_reset_i)
         bus_q <= wdbus_pkg::BUS_MODE_RST;
      else if (failsafe_entry_i)
         bus_q[4:0] <= wdbus_pkg::BUS_FAILSAFE_LO;
      else if (sleep_entry_i || stop_entry_i)
         bus_q[1:0] <= can_lp;
      else if (wr_bus)
         bus_q <= wdata;
   end

   // Refused watchdog write or malformed frame is reported as a failure
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         access_fail_o <= 1'b0;
      else if (frame_done && !frame_ok)
         access_fail_o <= 1'b1;
      else if (wr_en && addr == wdbus_pkg::ADDR_WDOG_CFG
               && odd_parity(wdata))
         access_fail_o <= 1'b1;
      else if (wr_en)
         access_fail_o <= 1'b0;
   end

   // Bus-wake start of the watchdog in stop state, registered request held high while the wake lasts
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         wdog_start_long_window_o <= 1'b0;
      else
         wdog_start_long_window_o <= in_stop_i && can_bus_wake_i
                                     && wd_q[wdbus_pkg::WD_BUSWAKE_BIT];
   end

   // Registered field outputs; all follow the stored register values
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         watchdog_config_o            <= wdbus_pkg::WDOG_CFG_RST;
         bus_transceiver_mode_o       <= wdbus_pkg::BUS_MODE_RST;
         wdog_stop_disable_lo_o       <= 1'b0;
         wdog_window_select_o         <= 1'b0;
         wdog_period_sel_o            <= wdbus_pkg::WDOG_PERIOD_RST;
         single_wire_slope_off_o      <= 1'b0;
         single_wire_low_slope_o      <= 1'b0;
         single_wire_txd_timeout_en_o <= 1'b1;
         single_wire_mode_o           <= wdbus_pkg::MODE_OFF;
         can_mode_o                   <= wdbus_pkg::MODE_OFF;
         selective_wake_o             <= 1'b0;
      end
      else
      begin
         watchdog_config_o            <= wd_q;
         bus_transceiver_mode_o       <= bus_q;
         wdog_stop_disable_lo_o       <= wd_q[wdbus_pkg::WD_STOP_DIS_BIT];
         wdog_window_select_o         <= wd_q[wdbus_pkg::WD_WINDOW_BIT];
         wdog_period_sel_o            <= wd_q[2:0];
         single_wire_slope_off_o      <= bus_q[wdbus_pkg::BM_FLASH_BIT];
         single_wire_low_slope_o      <= bus_q[wdbus_pkg::BM_LSLOPE_BIT];
         single_wire_txd_timeout_en_o <= bus_q[wdbus_pkg::BM_TXDTO_BIT];
         single_wire_mode_o           <= bus_q[4:3];
         can_mode_o                   <= bus_q[1:0];
         selective_wake_o             <= bus_q[wdbus_pkg::BM_SWK_BIT];
      end
   end

   // Checks on stored state and on the registered field outputs
   sequence s_host_bus_write;
      wr_bus && !failsafe_entry_i && !sleep_entry_i && !stop_entry_i
      && !srst_i && !soft_reset_i;
   endsequence

   // Accepted watchdog write that no restart or soft reset overrides
   sequence s_wd_host_write;
      wr_wd && !restart_entry_i && !soft_reset_i;
   endsequence

   // Odd-parity watchdog write with no competing event in that cycle
   sequence s_wd_bad_parity;
      wr_en && addr == wdbus_pkg::ADDR_WDOG_CFG && odd_parity(wdata)
      && !restart_entry_i && !soft_reset_i;
   endsequence

   // Low-power entry that neither fail-safe nor soft reset overrides
   sequence s_low_power_entry;
      (sleep_entry_i || stop_entry_i) && !failsafe_entry_i
      && !soft_reset_i;
   endsequence

   // Sleep entry; when stop is requested too, the sleep mapping applies
   sequence s_sleep_entry;
      sleep_entry_i && !failsafe_entry_i && !soft_reset_i;
   endsequence

   // Stop entry with no sleep request beside it
   sequence s_stop_entry;
      stop_entry_i && !sleep_entry_i && !failsafe_entry_i && !soft_reset_i;
   endsequence

   // Bus wake seen while the device sits in the stop state
   sequence s_bus_wake_in_stop;
      in_stop_i && can_bus_wake_i;
   endsequence

   AST_FLASH_APPLY: assert property (@(posedge clk_i)
      disable iff (srst_i)
      s_host_bus_write |-> ##2
      single_wire_slope_off_o == $past(wdata[7], 2))
      else $error("flash setting not applied after frame");

   AST_LOWSLOPE_APPLY: assert property (@(posedge clk_i)
      disable iff (srst_i)
      s_host_bus_write |-> ##2 single_wire_low_slope_o == $past(wdata[6], 2))
      else $error("low-slope setting not applied");

   AST_RSVD_ZERO: assert property (@(posedge clk_i)
      disable iff (srst_i)
      ##1 !watchdog_config_o[3])
      else $error("reserved watchdog bit read as one");

   AST_PARITY_REFUSE: assert property (@(posedge clk_i)
      disable iff (srst_i)
      s_wd_bad_parity |=> wd_q == $past(wd_q) ##1 access_fail_o)
      else $error("odd parity watchdog write accepted");

   AST_RESTART_LOAD: assert property (@(posedge clk_i)
      disable iff (srst_i)
      (restart_entry_i && !soft_reset_i) |=>
      wd_q[2:0] == wdbus_pkg::WDOG_PERIOD_RST && !wd_q[6]
      && wd_q[7] == $past(wd_q[7]) && wd_q[5] == $past(wd_q[5]))
      else $error("restart value wrong");

   // Restart keeps the bus-wake start bit and leaves the reserved bit low
   AST_RESTART_KEEP: assert property (@(posedge clk_i)
      disable iff (srst_i)
      (restart_entry_i && !soft_reset_i) |=>
      wd_q[4] == $past(wd_q[4]) && !wd_q[3])
      else $error("restart disturbed bits it must keep");

   AST_FAILSAFE: assert property (@(posedge clk_i)
      disable iff (srst_i)
      (failsafe_entry_i && !soft_reset_i) |=>
      bus_q[4:0] == wdbus_pkg::BUS_FAILSAFE_LO
      && bus_q[7:5] == $past(bus_q[7:5]))
      else $error("fail-safe reload wrong");

   // The fail-safe reload writes all five low bits, selective wake
   // included, so it and soft reset are the device actions exempt from this check
   AST_SWK_KEPT: assert property (@(posedge clk_i)
      disable iff (srst_i)
      (!wr_bus && !soft_reset_i && !failsafe_entry_i) |=> $stable(bus_q[2]))
      else $error("selective wake changed without a write");

   AST_SLEEP_NORMAL: assert property (@(posedge clk_i)
      disable iff (srst_i)
      s_sleep_entry ##0 (!system_error_flag_i
      && bus_q[1:0] == wdbus_pkg::MODE_NORMAL)
      |=> bus_q[1:0] == wdbus_pkg::MODE_WAKE)
      else $error("normal not turned wake capable on sleep");

   AST_SLEEP_RXONLY: assert property (@(posedge clk_i)
      disable iff (srst_i)
      s_sleep_entry ##0 (bus_q[1:0] == wdbus_pkg::MODE_RXONLY)
      |=> bus_q[1:0] == wdbus_pkg::MODE_WAKE)
      else $error("receive-only not turned wake capable on sleep");

   AST_STOP_RXONLY: assert property (@(posedge clk_i)
      disable iff (srst_i)
      s_stop_entry ##0 (bus_q[1:0] == wdbus_pkg::MODE_RXONLY)
      |=> bus_q[1:0] == wdbus_pkg::MODE_RXONLY)
      else $error("receive-only lost on stop entry");

   AST_LP_KEEP: assert property (@(posedge clk_i)
      disable iff (srst_i)
      s_low_power_entry ##0 !bus_q[1] |=> bus_q[1:0] == $past(bus_q[1:0]))
      else $error("off or wake capable mode changed on low-power entry");

   AST_BUS_WAKE_START: assert property (@(posedge clk_i)
      disable iff (srst_i)
      s_bus_wake_in_stop ##0 !wd_q[wdbus_pkg::WD_BUSWAKE_BIT]
      |=> !wdog_start_long_window_o)
      else $error("watchdog started with bus wake disabled");

   AST_BUS_WAKE_FIRE: assert property (@(posedge clk_i)
      disable iff (srst_i)
      s_bus_wake_in_stop ##0 wd_q[wdbus_pkg::WD_BUSWAKE_BIT]
      |=> wdog_start_long_window_o)
      else $error("watchdog not started on bus wake");

   AST_WD_WRITE: assert property (@(posedge clk_i)
      disable iff (srst_i)
      s_wd_host_write |=> wd_q[7:4] == $past(wdata[7:4])
      && wd_q[2:0] == $past(wdata[2:0]) && !wd_q[3])
      else $error("even parity watchdog write not stored");

   AST_BUS_WRITE: assert property (@(posedge clk_i)
      disable iff (srst_i)
      s_host_bus_write |=> bus_q == $past(wdata))
      else $error("bus mode write not stored");

   AST_SOFT_RESET: assert property (@(posedge clk_i)
      disable iff (srst_i)
      soft_reset_i |=> wd_q == wdbus_pkg::WDOG_CFG_RST
      && bus_q == wdbus_pkg::BUS_MODE_RST)
      else $error("soft reset did not reload the registers");

   // A frame of the wrong length must raise the failure flag by itself
   AST_FRAME_FAIL: assert property (@(posedge clk_i)
      disable iff (srst_i)
      (frame_done && !frame_ok) |=> access_fail_o)
      else $error("short frame not reported");

   AST_FAIL_CLEAR: assert property (@(posedge clk_i)
      disable iff (srst_i)
      s_wd_host_write |=> !access_fail_o)
      else $error("failure flag kept after a good write");

   // Field outputs are plain copies of the stored bits, one edge later
   AST_STOP_DIS_OUT: assert property (@(posedge clk_i)
      disable iff (srst_i)
      ##1 wdog_stop_disable_lo_o == $past(wd_q[6]))
      else $error("stop-disable output does not follow the register");

   AST_WINDOW_OUT: assert property (@(posedge clk_i)
      disable iff (srst_i)
      ##1 wdog_window_select_o == $past(wd_q[5]))
      else $error("window select output does not follow the register");

   AST_PERIOD_OUT: assert property (@(posedge clk_i)
      disable iff (srst_i)
      ##1 wdog_period_sel_o == $past(wd_q[2:0]))
      else $error("period output does not follow the register");
endmodule

// ### tb/tb.sv
// Testbench: serial writes, mode events and readback of the two registers
`timescale 1ns/1ps
module tb;
   logic        clk_i = 1'b0;
   logic        srst_i = 1'b1;
   logic        soft_reset_i = 1'b0;
   logic        chip_select_n_i = 1'b1;
   logic        sclk_i = 1'b0;
   logic        sdi_i = 1'b0;
   logic        restart_entry_i = 1'b0;
   logic        failsafe_entry_i = 1'b0;
   logic        sleep_entry_i = 1'b0;
   logic        stop_entry_i = 1'b0;
   logic        in_stop_i = 1'b0;
   logic        can_bus_wake_i = 1'b0;
   logic        system_error_flag_i = 1'b0;
   logic [7:0]  watchdog_config_o;
   logic [7:0]  bus_transceiver_mode_o;
   logic        wdog_stop_disable_lo_o;
   logic        wdog_window_select_o;
   logic [2:0]  wdog_period_sel_o;
   logic        wdog_start_long_window_o;
   logic        single_wire_slope_off_o;
   logic        single_wire_low_slope_o;
   logic        single_wire_txd_timeout_en_o;
   logic [1:0]  single_wire_mode_o;
   logic [1:0]  can_mode_o;
   logic        selective_wake_o;
   logic        access_fail_o;
   logic        chk = 1'b0;
   logic [30:0] exp_q [$];
   logic [30:0] e;
   logic [7:0]  wd_m = 8'h14;
   logic [7:0]  bus_m = 8'h20;
   logic        fail_m = 1'b0;
   logic [7:0]  pulses_m = 8'h00;
   logic [7:0]  pulse_cnt;
   int          fail_count = 0;
   int          n_tests = 0;
   wire  [29:0] obs = {watchdog_config_o, bus_transceiver_mode_o,
      access_fail_o, wdog_stop_disable_lo_o, wdog_window_select_o,
      wdog_period_sel_o, single_wire_slope_off_o, single_wire_low_slope_o,
      single_wire_txd_timeout_en_o, single_wire_mode_o, can_mode_o,
      selective_wake_o};

   watchdog_and_bus_mode_regs watchdog_and_bus_mode_regs_inst
   (
      .clk_i(clk_i), .srst_i(srst_i), .soft_reset_i(soft_reset_i),
      .chip_select_n_i(chip_select_n_i), .sclk_i(sclk_i), .sdi_i(sdi_i),
      .restart_entry_i(restart_entry_i), .failsafe_entry_i(failsafe_entry_i),
      .sleep_entry_i(sleep_entry_i), .stop_entry_i(stop_entry_i),
      .in_stop_i(in_stop_i), .can_bus_wake_i(can_bus_wake_i),
      .system_error_flag_i(system_error_flag_i),
      .watchdog_config_o(watchdog_config_o),
      .bus_transceiver_mode_o(bus_transceiver_mode_o),
      .wdog_stop_disable_lo_o(wdog_stop_disable_lo_o),
      .wdog_window_select_o(wdog_window_select_o),
      .wdog_period_sel_o(wdog_period_sel_o),
      .wdog_start_long_window_o(wdog_start_long_window_o),
      .single_wire_slope_off_o(single_wire_slope_off_o),
      .single_wire_low_slope_o(single_wire_low_slope_o),
      .single_wire_txd_timeout_en_o(single_wire_txd_timeout_en_o),
      .single_wire_mode_o(single_wire_mode_o), .can_mode_o(can_mode_o),
      .selective_wake_o(selective_wake_o), .access_fail_o(access_fail_o)
   );

   // 50 MHz clock
   always #10 clk_i = ~clk_i;

   // Count start pulses so a stuck-high output shows as a wrong count
   always @(posedge clk_i)
   begin
      if (srst_i)
         pulse_cnt <= 8'h00;
      else if (wdog_start_long_window_o === 1'b1)
         pulse_cnt <= pulse_cnt + 8'h01;
   end

   // Take the oldest note and compare it with what the block shows now
   always @(posedge clk_i)
   begin
      if (chk)
      begin
         e = exp_q.pop_front();
         if (e[30]) cmp_cnt(e[7:0], pulse_cnt);
         else cmp_regs(e[29:0], obs);
      end
   end

   task automatic cmp_regs(input logic [29:0] x, input logic [29:0] o);
      n_tests++;
      if (o !== x)
      begin
         fail_count++;
         $display("unexpected at %0t: regs %h want %h", $time, o, x);
      end
   endtask

   task automatic cmp_cnt(input logic [7:0] x, input logic [7:0] o);
      n_tests++;
      if (o !== x)
      begin
         fail_count++;
         $display("unexpected at %0t: pulses %0d want %0d", $time, o, x);
      end
   endtask

   // Expected outputs follow the model registers field by field
   function automatic logic [29:0] exp_vec();
      return {wd_m, bus_m, fail_m, wd_m[6], wd_m[5], wd_m[2:0], bus_m[7],
         bus_m[6], bus_m[5], bus_m[4:3], bus_m[1:0], bus_m[2]};
   endfunction

   function automatic logic [7:0] ev(input logic [6:0] v);
      return {^v, v};
   endfunction

   task automatic note(input logic k);
      exp_q.push_back(k ? {1'b1, 22'h0, pulses_m} : {1'b0, exp_vec()});
      chk = 1'b1;
      @(negedge clk_i);
      chk = 1'b0;
   endtask

   // Frame is n bits MSB first; n other than 16 is a malformed frame
   task automatic frame(input logic [6:0] a, input logic [7:0] d, input int n);
      logic [15:0] f;
      f = {1'b1, a, d};
      chip_select_n_i = 1'b0;
      @(negedge clk_i);
      for (int i = 0; i < n; i++)
      begin
         sdi_i = f[15 - i];
         repeat (2) @(negedge clk_i);
         sclk_i = 1'b1;
         repeat (2) @(negedge clk_i);
         sclk_i = 1'b0;
      end
      @(negedge clk_i);
      chip_select_n_i = 1'b1;
      sdi_i = ~sdi_i;
      repeat (6) @(negedge clk_i);
   endtask

   task automatic wr_wd(input logic [7:0] d);
      frame(wdbus_pkg::ADDR_WDOG_CFG, d, 16);
      fail_m = ^d;
      if (!fail_m) wd_m = d & 8'hf7;
   endtask

   task automatic wr_bus(input logic [7:0] d);
      frame(wdbus_pkg::ADDR_BUS_MODE, d, 16);
      bus_m = d;
      fail_m = 1'b0;
   endtask

   // s: 0 restart, 1 fail-safe, 2 sleep, 3 stop
   task automatic pulse(input int s);
      {restart_entry_i, failsafe_entry_i, sleep_entry_i, stop_entry_i} =
         4'h8 >> s;
      @(negedge clk_i);
      {restart_entry_i, failsafe_entry_i, sleep_entry_i, stop_entry_i} = 4'h0;
      repeat (5) @(negedge clk_i);
   endtask

   task automatic close_out();
      $display("tests %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Whole run is under 5000 cycles; give it ample margin
   initial
   begin
      #1000000;
      fail_count++;
      $display("unexpected at %0t: run did not finish", $time);
      close_out();
   end

   // Main sequence
   initial
   begin
      logic [31:0] x;
      logic [1:0]  m;
      void'($urandom(32'h0387805e));
      repeat (5) @(negedge clk_i);
      srst_i = 1'b0;
      @(negedge clk_i);
      note(0);
      $display("test reset done");
      repeat (6)
      begin
         x = $urandom;
         wr_wd(ev(x[6:0]));
         note(0);
      end
      for (int p = 0; p < 7; p++)
      begin
         x = $urandom;
         wr_wd(ev({x[6:3], p[2:0]}));
         note(0);
      end
      $display("test watchdog writes done");
      x = $urandom;
      wr_wd({~^x[6:0], x[6:0]});
      note(0);
      wr_wd(ev(7'h25));
      frame(wdbus_pkg::ADDR_BUS_MODE, x[7:0], 15);
      fail_m = 1'b1;
      note(0);
      wr_wd(ev(7'h7b));
      pulse(0);
      wd_m = {wd_m[7], 1'b0, wd_m[5:4], 4'b0100};
      note(0);
      $display("test refusal and restart done");
      repeat (6)
      begin
         x = $urandom;
         wr_bus(x[7:0]);
         note(0);
      end
      for (int c = 0; c < 16; c++)
      begin
         m = c[1:0];
         if (c[3] && m == 2'b11) continue;
         wr_bus({5'b10101, c[2:0]});
         system_error_flag_i = (m == 2'b10);
         pulse(c[3] ? 3 : 2);
         system_error_flag_i = 1'b0;
         if (m == 2'b11 || (!c[3] && m == 2'b10)) bus_m[1:0] = 2'b01;
         note(0);
      end
      x = $urandom;
      wr_bus(x[7:0]);
      pulse(1);
      bus_m = {bus_m[7:5], 5'b01001};
      note(0);
      $display("test bus modes done");
      for (int b = 0; b < 2; b++)
      begin
         wr_wd(ev({2'b00, b[0], 4'b0010}));
         in_stop_i = 1'b1;
         can_bus_wake_i = 1'b1;
         @(negedge clk_i);
         can_bus_wake_i = 1'b0;
         repeat (5) @(negedge clk_i);
         in_stop_i = 1'b0;
         pulses_m = pulses_m + {7'h0, b[0]};
         note(1);
      end
      soft_reset_i = 1'b1;
      @(negedge clk_i);
      soft_reset_i = 1'b0;
      repeat (5) @(negedge clk_i);
      wd_m = 8'h14;
      bus_m = 8'h20;
      note(0);
      $display("test bus wake and soft reset done");
      close_out();
   end
endmodule
